// ---- core/cvr_consts.vh ----
`ifndef CVR_CONSTS_VH
`define CVR_CONSTS_VH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define CVR_CH3_COMPARE_OFS 8'h3C
`define CVR_CH4_COMPARE_OFS 8'h40
`define CVR_CTRL_OFS 8'h48
`define CVR_REPEAT_OFS 8'h4C
`define CVR_STATUS_OFS 8'h50

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CVR_CTRL_CH3_PE 0
`define CVR_CTRL_CH4_PE 1
`define CVR_CTRL_CH3_IN 2
`define CVR_CTRL_CH4_IN 3
`define CVR_CTRL_CNT_EN 4
`define CVR_CTRL_W 5
`define CVR_REP_W 8
`define CVR_CNT_TOP 16'hFFFF

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CVR_VALUE_RST 16'h0000
`define CVR_CTRL_RST 5'h00
`define CVR_REP_RST 8'h00
`define CVR_CNT_RST 16'h0000

`endif

// ---- core/cvr_repeat_ctr.v ----
`include "cvr_consts.vh"

module cvr_repeat_ctr (
    input wire pclk,
    input wire presetn,
    input wire period_end,
    input wire [`CVR_REP_W-1:0] repeat_reload_value,
    output reg update_event,
    output reg [`CVR_REP_W-1:0] repeat_downcounter
);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            repeat_downcounter <= `CVR_REP_RST;
            update_event <= 1'b0;
        end else begin
            update_event <= 1'b0;
            if (period_end) begin
                if (repeat_downcounter == {`CVR_REP_W{1'b0}}) begin
                    update_event <= 1'b1;
                    // Reload only here, so new repeat values wait until the downcounter has run out at a period end
                    repeat_downcounter <= repeat_reload_value;
                end else begin
                    repeat_downcounter <= repeat_downcounter - 8'h01;
                end
            end
        end
    end

endmodule

// ---- core/cvr_compare_regs.v ----
`include "cvr_consts.vh"

module cvr_compare_regs (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire ch3_input_capture,
    input wire ch4_input_capture,
    output reg ch3_compare_output,
    output reg ch4_compare_output,
    output reg [15:0] timer_counter_value,
    output wire update_event
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire wr_en = psel && penable && pwrite;
    wire hit3 = (paddr == `CVR_CH3_COMPARE_OFS);
    wire hit4 = (paddr == `CVR_CH4_COMPARE_OFS);
    wire hitc = (paddr == `CVR_CTRL_OFS);
    wire hitr = (paddr == `CVR_REPEAT_OFS);
    wire hits = (paddr == `CVR_STATUS_OFS);
    wire mapped = hit3 | hit4 | hitc | hitr | hits;

    reg [15:0] ch3_compare_value_r;
    reg [15:0] ch4_compare_value_r;
    reg [15:0] ch3_active_r;
    reg [15:0] ch4_active_r;
    reg [`CVR_CTRL_W-1:0] ctrl_r;
    reg [`CVR_REP_W-1:0] repeat_reload_value_r;
    reg [31:0] rdata_r;
    wire [`CVR_REP_W-1:0] repeat_downcounter;

    // Byte-lane merge of low halfword; upper lanes are reserved
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] wd;
        input [3:0] st;
        begin
            merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
        end
    endfunction

    // Compare result is forced low in input mode
    function cmp_high;
        input in_mode;
        input [15:0] cnt;
        input [15:0] act;
        begin
            cmp_high = !in_mode && (cnt < act);
        end
    endfunction

    wire ch3_pe = ctrl_r[`CVR_CTRL_CH3_PE];
    wire ch4_pe = ctrl_r[`CVR_CTRL_CH4_PE];
    wire ch3_in = ctrl_r[`CVR_CTRL_CH3_IN];
    wire ch4_in = ctrl_r[`CVR_CTRL_CH4_IN];

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = rdata_r;

    // ------------------------------------------------------------
    // Capture pin synchronisers and edge detect
    // ------------------------------------------------------------
    reg [1:0] cap3_s;
    reg [1:0] cap4_s;
    reg cap3_d;
    reg cap4_d;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap3_s <= 2'h0;
            cap4_s <= 2'h0;
            cap3_d <= 1'b0;
            cap4_d <= 1'b0;
        end else begin
            cap3_s <= {cap3_s[0], ch3_input_capture};
            cap4_s <= {cap4_s[0], ch4_input_capture};
            cap3_d <= cap3_s[1];
            cap4_d <= cap4_s[1];
        end
    end
    wire cap3_evt = cap3_s[1] && !cap3_d;
    wire cap4_evt = cap4_s[1] && !cap4_d;

    // ------------------------------------------------------------
    // Free-running up counter; wrap marks a period end
    // ------------------------------------------------------------
    // Top value only: no auto-reload register in this block
    wire period_end = ctrl_r[`CVR_CTRL_CNT_EN] && (timer_counter_value == `CVR_CNT_TOP);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            timer_counter_value <= `CVR_CNT_RST;
        else if (ctrl_r[`CVR_CTRL_CNT_EN])
            timer_counter_value <= timer_counter_value + 16'h0001;
    end

    cvr_repeat_ctr u_rep (
        .pclk(pclk),
        .presetn(presetn),
        .period_end(period_end),
        .repeat_reload_value(repeat_reload_value_r),
        .update_event(update_event),
        .repeat_downcounter(repeat_downcounter)
    );

    // ------------------------------------------------------------
    // Control and repeat registers
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `CVR_CTRL_RST;
            repeat_reload_value_r <= `CVR_REP_RST;
        end else begin
            if (wr_en && hitc && pstrb[0])
                ctrl_r <= pwdata[`CVR_CTRL_W-1:0];
            if (wr_en && hitr && pstrb[0])
                repeat_reload_value_r <= pwdata[`CVR_REP_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Channel three value and active register
    // ------------------------------------------------------------
    // clear at reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch3_compare_value_r <= `CVR_VALUE_RST;
            ch3_active_r <= `CVR_VALUE_RST;
        end else if (ch3_in) begin
            // Software writes dropped so a capture is not overwritten
            // latch counter on capture
            if (cap3_evt)
                ch3_compare_value_r <= timer_counter_value;
        end else begin
            if (wr_en && hit3)
                ch3_compare_value_r <= merge16(ch3_compare_value_r, pwdata, pstrb);
            if (!ch3_pe) begin
                // Same edge as the write, so the compare never sees a stale value
                if (wr_en && hit3)
                    ch3_active_r <= merge16(ch3_compare_value_r, pwdata, pstrb);
                else
                    ch3_active_r <= ch3_compare_value_r;
            end else if (update_event) begin
                ch3_active_r <= ch3_compare_value_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Channel four value and active register
    // ------------------------------------------------------------
    // clear at reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch4_compare_value_r <= `CVR_VALUE_RST;
            ch4_active_r <= `CVR_VALUE_RST;
        end else if (ch4_in) begin
            // Software writes dropped so a capture is not overwritten
            // latch counter on capture
            if (cap4_evt)
                ch4_compare_value_r <= timer_counter_value;
        end else begin
            if (wr_en && hit4)
                ch4_compare_value_r <= merge16(ch4_compare_value_r, pwdata, pstrb);
            if (!ch4_pe) begin
                // Same edge as the write, so the compare never sees a stale value
                if (wr_en && hit4)
                    ch4_active_r <= merge16(ch4_compare_value_r, pwdata, pstrb);
                else
                    ch4_active_r <= ch4_compare_value_r;
            end else if (update_event) begin
                ch4_active_r <= ch4_compare_value_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Compare outputs: high while counter below active value
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch3_compare_output <= 1'b0;
            ch4_compare_output <= 1'b0;
        end else begin
            ch3_compare_output <= cmp_high(ch3_in, timer_counter_value, ch3_active_r);
            ch4_compare_output <= cmp_high(ch4_in, timer_counter_value, ch4_active_r);
        end
    end

    // ------------------------------------------------------------
    // Read data, registered in setup phase
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 32'h00000000;
        end else if (psel && !penable) begin
            // Flop output lets pready stay tied high
            // reserved bits zero
            if (hit3)
                rdata_r <= {16'h0000, ch3_compare_value_r};
            else if (hit4)
                rdata_r <= {16'h0000, ch4_compare_value_r};
            else if (hitc)
                rdata_r <= {27'h0000000, ctrl_r};
            else if (hitr)
                rdata_r <= {24'h000000, repeat_reload_value_r};
            else if (hits)
                rdata_r <= {8'h00, repeat_downcounter, timer_counter_value};
            else
                rdata_r <= 32'h00000000;
        end
    end

endmodule

// ---- verif/cvr_compare_regs_monitor.sv ----
`include "cvr_consts.vh"

module cvr_compare_regs_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire ch3_compare_output,
    input wire ch4_compare_output,
    input wire [15:0] timer_counter_value,
    input wire update_event
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire val = paddr == `CVR_CH3_COMPARE_OFS || paddr == `CVR_CH4_COMPARE_OFS;
    wire map = val || paddr == `CVR_CTRL_OFS || paddr == `CVR_REPEAT_OFS
        || paddr == `CVR_STATUS_OFS;
    AST_UNMAPPED_ERR: assert property (acc && !map |-> pslverr && pready)
        else $error("unmapped access not refused");
    AST_MAPPED_OK: assert property (acc && map |-> !pslverr)
        else $error("mapped access refused");
    AST_UPPER_ZERO: assert property (acc && !pwrite && val |-> prdata[31:16] == 16'h0000)
        else $error("reserved bits not zero");
    AST_RDATA_STANDS: assert property (!psel |=> $stable(prdata))
        else $error("read data moved outside a transfer");
    AST_UEV_PULSE: assert property (update_event |=> !update_event)
        else $error("update event longer than one cycle");
    AST_UEV_WRAP: assert property (update_event |-> $past(timer_counter_value) == 16'hFFFF)
        else $error("update event away from period end");
    AST_CH3_MAX: assert property (timer_counter_value == 16'hFFFF |=> !ch3_compare_output)
        else $error("channel three high at counter top");
    AST_CH4_MAX: assert property (timer_counter_value == 16'hFFFF |=> !ch4_compare_output)
        else $error("channel four high at counter top");
    COV_WRITE: cover property (acc && pwrite && val);
    COV_UEV: cover property (update_event);
    COV_CH3_RISE: cover property ($rose(ch3_compare_output));
endmodule

bind cvr_compare_regs cvr_compare_regs_monitor cvr_compare_regs_monitor_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .update_event(update_event),
    .ch3_compare_output(ch3_compare_output), .ch4_compare_output(ch4_compare_output),
    .timer_counter_value(timer_counter_value));

// ---- verif/test_cvr_compare_regs.sv ----
module test_cvr_compare_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic ch3_input_capture = 0, ch4_input_capture = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic [15:0] v;
    wire [31:0] prdata;
    wire [15:0] timer_counter_value;
    wire pready, pslverr, ch3_compare_output, ch4_compare_output, update_event;
    integer num_errors = 0, cmp_count = 0, n;
    always #2 pclk = ~pclk;
    cvr_compare_regs cvr_compare_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .update_event(update_event),
        .ch3_input_capture(ch3_input_capture), .ch4_input_capture(ch4_input_capture),
        .ch3_compare_output(ch3_compare_output), .ch4_compare_output(ch4_compare_output),
        .timer_counter_value(timer_counter_value));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Idle cycle after each transfer keeps drivers single-assigned per step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a wait for pready
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, er}, {31'h0, e});
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(8'h3C, 32'h0, 1'b0);
        rdc(8'h40, 32'h0, 1'b0);
        rdc(8'h44, 32'h0, 1'b1);
        wr(8'h3C, 32'h00000010);
        rdc(8'h3C, 32'h10, 1'b0);
        wr(8'h40, 32'h0000ABCD);
        rdc(8'h40, 32'hABCD, 1'b0);
        wr(8'h48, 32'h10);
        repeat (4) @(negedge pclk);
        chk(ch3_compare_output, 1);
        repeat (20) @(negedge pclk);
        chk(ch3_compare_output, 0);
        chk(ch4_compare_output, 1);
        @(posedge pclk);
        // Preload on: new values wait for the update event
        wr(8'h48, 32'h13);
        wr(8'h4C, 32'h03);
        wr(8'h3C, 32'h20);
        wr(8'h40, 32'h5);
        rdc(8'h3C, 32'h20, 1'b0);
        @(negedge pclk);
        chk(ch4_compare_output, 1);
        for (n = 0; update_event !== 1'b1 && n < 70000; n++) @(negedge pclk);
        chk(update_event, 1);
        for (n = 0; timer_counter_value !== 16'h0018 && n < 100; n++) @(negedge pclk);
        repeat (2) @(negedge pclk);
        chk(ch3_compare_output, 1);
        chk(ch4_compare_output, 0);
        chk(timer_counter_value, 32'h1A);
        @(posedge pclk);
        // Counter stopped so the captured value is known
        wr(8'h48, 32'h0C);
        repeat (2) @(negedge pclk);
        v = timer_counter_value;
        @(posedge pclk);
        rdc(8'h50, {8'h00, 8'h03, v}, 1'b0);
        ch3_input_capture <= 1'b1;
        ch4_input_capture <= 1'b1;
        repeat (3) @(posedge pclk);
        ch3_input_capture <= 1'b0;
        ch4_input_capture <= 1'b0;
        repeat (6) @(posedge pclk);
        wr(8'h3C, 32'h77);
        rdc(8'h3C, {16'h0, v}, 1'b0);
        rdc(8'h40, {16'h0, v}, 1'b0);
        end_of_test;
    end
    initial begin
        #300000;
        num_errors++;
        end_of_test;
    end
endmodule
